// ==== logic/ctp_defines.svh ====
// Purpose: constants for the tape i/o port
// Assumes: 8-bit port number on upper address byte
// Notes: none
`ifndef CTP_DEFINES_SVH
`define CTP_DEFINES_SVH
`define CTP_PORT_NUM_W     8
`define CTP_ADDR_LO        8
`define CTP_ADDR_HI        15
`define CTP_OUT_BITS       4
`define CTP_IN_BITS        4
`define CTP_TONE_IN_BIT    0
`define CTP_OUT_RESET      4'h1
`define CTP_DIN_IDLE       8'h00
`endif

// ==== logic/ctp_pkg.sv ====
// Purpose: types for the tape i/o port
// Assumes: nothing
// Notes: none
package ctp_pkg;
	typedef enum logic [2:0] {
		CTP_IDLE  = 3'b001,
		CTP_READ  = 3'b010,
		CTP_WRITE = 3'b100
	} ctp_state_type;
endpackage : ctp_pkg

// ==== logic/ctp_sync.sv ====
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input asynchronous to clk
// Notes: output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ctp_sync #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] s1_r, s2_r, s3_r, q_r;
	logic [W-1:0] s1_nxt, s2_nxt, s3_nxt, q_nxt_bit;
	genvar i;

	always_comb begin
		s1_nxt = d;
		s2_nxt = s1_r;
		s3_nxt = s2_r;
	end
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_comb begin
				if (s2_r[i] == s3_r[i]) begin
					q_nxt_bit[i] = s3_r[i];
				end else begin
					q_nxt_bit[i] = q_r[i];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q_r  <= '0;
		end else if (ce) begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
			q_r  <= q_nxt_bit;
		end
	end
	assign q = q_r;
endmodule : ctp_sync
`default_nettype wire

// ==== logic/ctp_port.sv ====
// Purpose: bus side of a single-address cassette tape i/o port
// Assumes: bus strobes are synchronous to clk; tape inputs are asynchronous
// Notes: outputs are registered, so answers appear one clock after the strobe
`timescale 1ns/1ps
`default_nettype none
`include "ctp_defines.svh"
module ctp_port
	import ctp_pkg::*;
#(
	parameter int OUT_W = `CTP_OUT_BITS,
	parameter int IN_W  = `CTP_IN_BITS
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              ce,
	input  wire logic [15:0]       addr,
	input  wire logic [7:0]        port_sel,
	input  wire logic              status_in,
	input  wire logic              status_out,
	input  wire logic              dbin,
	input  wire logic              wr_n,
	input  wire logic [7:0]        data_out_bus,
	input  wire logic [IN_W-1:0]   tape_in,
	output var  logic [7:0]        data_in_bus,
	output var  logic              data_in_oe,
	output var  logic              ready,
	output var  logic              ready_oe,
	output var  logic [OUT_W-1:0]  tape_out,
	output var  logic              tape_out_bit_high
);
	localparam logic [OUT_W-1:0] LATCH_RST = OUT_W'(`CTP_OUT_RESET);

	logic [IN_W-1:0]  in_sync;
	logic [7:0]       sel_r;
	logic [7:0]       sel_nxt;
	logic             sel_ok_r;
	logic             sel_ok_nxt;
	logic             hit;
	logic             rd_hit;
	logic             wr_hit;
	ctp_state_type    state_r;
	ctp_state_type    state_nxt;
	logic [OUT_W-1:0] latch_r;
	logic [OUT_W-1:0] latch_nxt;
	logic             bit_high_r;
	logic             bit_high_nxt;
	logic [7:0]       din_bits;
	logic [7:0]       din_r;
	logic [7:0]       din_nxt;
	logic             oe_r;
	logic             oe_nxt;
	logic             rdy_r;
	logic             rdy_nxt;
	logic             rdy_oe_r;
	logic             rdy_oe_nxt;
	genvar            b;

	// strap is sampled after reset, never loaded under the reset itself
	function automatic logic addr_match(input logic [15:0] a, input logic [7:0] s);
		addr_match = (a[`CTP_ADDR_HI:`CTP_ADDR_LO] == s);
	endfunction : addr_match

	ctp_sync #(.W(IN_W)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.d     (tape_in),
		.q     (in_sync)
	);

	// bus lines share clk, so the decode needs no synchroniser
	assign hit = sel_ok_r && addr_match(addr, sel_r) && (status_in || status_out);
	// read wins when both strobes show in one cycle
	assign rd_hit = hit && dbin;
	assign wr_hit = hit && !dbin && !wr_n;

	// unused data-in bits read as zero, never float
	generate
		for (b = 0; b < 8; b++) begin : g_din
			if (b < IN_W) begin : g_live
				assign din_bits[b] = in_sync[b];
			end else begin : g_zero
				assign din_bits[b] = 1'b0;
			end
		end
	endgenerate

	// strap capture: a later strap change is ignored until the next reset
	always_comb begin
		sel_nxt    = sel_r;
		sel_ok_nxt = 1'b1;
		if (!sel_ok_r) begin
			sel_nxt = port_sel;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_r    <= 8'h00;
			sel_ok_r <= 1'b0;
		end else if (ce) begin
			sel_r    <= sel_nxt;
			sel_ok_r <= sel_ok_nxt;
		end
	end

	// cycle kind, kept for observation only
	always_comb begin
		state_nxt = CTP_IDLE;
		case (state_r)
			CTP_IDLE, CTP_READ, CTP_WRITE: begin
				if (rd_hit) begin
					state_nxt = CTP_READ;
				end else if (wr_hit) begin
					state_nxt = CTP_WRITE;
				end
			end
			default: begin
				state_nxt = CTP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= CTP_IDLE;
		end else if (ce) begin
			state_r <= state_nxt;
		end
	end

	// output latch: only a write hit changes it, so tones need steady rewrites
	always_comb begin
		latch_nxt = latch_r;
		if (wr_hit) begin
			latch_nxt = data_out_bus[OUT_W-1:0];
		end
		bit_high_nxt = latch_nxt[1];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_r    <= LATCH_RST;
			bit_high_r <= LATCH_RST[1];
		end else if (ce) begin
			latch_r    <= latch_nxt;
			bit_high_r <= bit_high_nxt;
		end
	end

	// read data: idle value between reads keeps the shared bus quiet
	always_comb begin
		din_nxt = `CTP_DIN_IDLE;
		if (rd_hit) begin
			din_nxt = din_bits;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			din_r <= `CTP_DIN_IDLE;
		end else if (ce) begin
			din_r <= din_nxt;
		end
	end

	// read enable: one cycle per read hit cycle
	always_comb begin
		oe_nxt = rd_hit;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			oe_r <= 1'b0;
		end else if (ce) begin
			oe_r <= oe_nxt;
		end
	end

	// ready: no wait states, so it simply follows the decode one clock late
	always_comb begin
		rdy_nxt = hit;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdy_r <= 1'b0;
		end else if (ce) begin
			rdy_r <= rdy_nxt;
		end
	end

	// ready is driven only while this port is addressed
	always_comb begin
		rdy_oe_nxt = hit;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdy_oe_r <= 1'b0;
		end else if (ce) begin
			rdy_oe_r <= rdy_oe_nxt;
		end
	end

	assign data_in_bus       = din_r;
	assign data_in_oe        = oe_r;
	assign ready             = rdy_r;
	assign ready_oe          = rdy_oe_r;
	assign tape_out          = latch_r;
	assign tape_out_bit_high = bit_high_r;
endmodule : ctp_port
`default_nettype wire

// ==== sim/ctp_port_checker.sv ====
// Purpose: port checker
// Assumes: strap held static
// Notes: none
`timescale 1ns/1ps
`default_nettype none
module ctp_port_checker #(parameter int OUT_W = 4) (
	input wire logic clk, rst_n, ce, dbin, wr_n, status_in, status_out,
	input wire logic ready, ready_oe, data_in_oe, tape_out_bit_high,
	input wire logic [15:0] addr,
	input wire logic [7:0] port_sel, data_out_bus, data_in_bus,
	input wire logic [OUT_W-1:0] tape_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire hit = ce && addr[15:8] == port_sel && (status_in || status_out);
	sequence rd_s; hit && dbin; endsequence
	sequence wr_s; hit && !dbin && !wr_n; endsequence
	ready_hit_a: assert property (hit |=> ready && ready_oe) else $error("no ready");
	addr_miss_a: assert property (addr[15:8] != port_sel |=> !ready) else $error("ready");
	no_status_a: assert property (!status_in && !status_out |=> !ready) else $error("rdy");
	read_drive_a: assert property (rd_s |=> data_in_oe && data_in_bus[7:4] == 4'h0) else $error("rd");
	read_idle_a: assert property (!(hit && dbin) |=> data_in_bus == 8'h00) else $error("bus");
	write_latch_a: assert property (wr_s |=> tape_out == $past(data_out_bus[OUT_W-1:0])) else $error("wr");
	latch_hold_a: assert property (!(hit && !dbin && !wr_n) |=> $stable(tape_out)) else $error("hold");
	bit_high_a: assert property (tape_out_bit_high == tape_out[1]) else $error("bit1");
endmodule : ctp_port_checker
bind ctp_port ctp_port_checker #(.OUT_W(OUT_W)) chk_u (.*);
`default_nettype wire

// ==== sim/ctp_host.sv ====
// Purpose: bus master model
// Assumes: request held until ready is sampled
// Notes: released address and data lines show inverted values; status and strobe lines go idle
`timescale 1ns/1ps
`default_nettype none
module ctp_host (
	input wire logic clk, ready,
	input wire logic [7:0] data_in_bus,
	output logic [15:0] addr,
	output logic status_in, status_out, dbin, wr_n,
	output logic [7:0] data_out_bus
);
	initial {addr, status_in, status_out, dbin, wr_n, data_out_bus} = {16'hFFFF, 4'h1, 8'h00};
	task automatic io(input logic rd, st, input logic [7:0] p, d, output logic rdy, output logic [7:0] q);
		@(posedge clk);
		{addr, status_in, status_out, dbin, wr_n, data_out_bus} <= {p, d, st & rd, st & !rd, rd, rd, d};
		repeat (2) @(posedge clk);
		rdy = ready;
		q = data_in_bus;
		{addr, status_in, status_out, dbin, wr_n, data_out_bus} <= {~p, ~d, 4'h1, ~d};
	endtask : io
endmodule : ctp_host
`default_nettype wire

// ==== sim/cassette_tape_io_port_tb_top.sv ====
// Purpose: port bench
// Assumes: ce held high except for one write with ce low
// Notes: random from fixed seed
`timescale 1ns/1ps
`default_nettype none
module cassette_tape_io_port_tb_top;
	logic clk = 0, rst_n = 0, ce = 1, ready, ready_oe, data_in_oe, hi, rdy, status_in, status_out;
	logic dbin, wr_n;
	logic [3:0] tape_in = 0, tape_out, exp_out = 4'h1;
	logic [7:0] port_sel = 8'hC4, din, q, dout;
	logic [15:0] addr;
	logic [31:0] seed = 32'h922B;
	int failures = 0, compares = 0;
	always #25 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction : xs
	ctp_port dut_u (.clk, .rst_n, .ce, .addr, .port_sel, .status_in, .status_out, .dbin,
		.wr_n, .data_out_bus(dout), .tape_in, .data_in_bus(din), .data_in_oe, .ready, .ready_oe,
		.tape_out, .tape_out_bit_high(hi));
	ctp_host host_u (.clk, .ready, .data_in_bus(din), .addr, .status_in, .status_out, .dbin, .wr_n,
		.data_out_bus(dout));
	task automatic check(input string n, input logic [7:0] e, s);
		compares++;
		if (s !== e) begin
			failures++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask : check
	task automatic stop_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task automatic op(input logic rd, st, input logic [7:0] p, d);
		logic h;
		h = st && p === port_sel;
		host_u.io(rd, st, p, d, rdy, q);
		if (h && !rd) exp_out = d[3:0];
		check("ready", h, rdy);
		check("ready_oe", h, ready_oe);
		check("rd_oe", h && rd, data_in_oe);
		check("rdata", h && rd ? {4'h0, tape_in} : 8'h00, q);
		check("latch", exp_out, tape_out);
		check("bit1", exp_out[1], hi);
	endtask : op
	initial begin
		repeat (3000) @(posedge clk);
		failures++;
		stop_test();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1;
		repeat (3) @(posedge clk);
		check("reset", 4'h1, tape_out);
		for (int i = 0; i < 6; i++) op(0, 1, port_sel, i[0] ? 8'h00 : 8'hF3);
		op(0, 1, port_sel, 8'h01);
		op(1, 1, port_sel ^ 8'h80, 8'h00);
		ce <= 0;
		host_u.io(0, 1, port_sel, 8'h0A, rdy, q);
		check("frozen", exp_out, tape_out);
		check("frozen_rdy", 8'h00, rdy);
		ce <= 1;
		$display("tone test done");
		for (int i = 0; i < 40; i++) begin
			seed = xs(seed);
			tape_in <= seed[3:0];
			repeat (6) @(posedge clk);
			op(seed[4], seed[5] | seed[6], seed[7] ? port_sel : seed[15:8], seed[23:16]);
		end
		$display("random test done");
		stop_test();
	end
endmodule : cassette_tape_io_port_tb_top
`default_nettype wire
